// ===== design/cpdb_pkg.sv
// package: register map, field layout and types of the cpu port dma channel
package cpdb_pkg;
    // register word indices (printed offsets are not word multiples: byte address is index * 4)
    localparam logic [7:0] CPDB_IDX_CONFIG = 8'h81;
    localparam logic [7:0] CPDB_IDX_CONTROL = 8'h82;
    localparam logic [7:0] CPDB_IDX_LEVEL_H = 8'h84;
    localparam logic [7:0] CPDB_IDX_LEVEL_L = 8'h85;
    localparam logic [7:0] CPDB_IDX_COUNT_B3 = 8'h88;
    localparam logic [7:0] CPDB_IDX_COUNT_B2 = 8'h89;
    localparam logic [7:0] CPDB_IDX_COUNT_B1 = 8'h8A;
    localparam logic [7:0] CPDB_IDX_COUNT_B0 = 8'h8B;
    localparam logic [7:0] CPDB_IDX_RD_PORT0 = 8'h8C;
    localparam logic [7:0] CPDB_IDX_RD_PORT1 = 8'h8D;
    localparam logic [7:0] CPDB_IDX_WR_PORT0 = 8'h8E;
    localparam logic [7:0] CPDB_IDX_WR_PORT1 = 8'h8F;
    // registers of our own: event status and fifo attach
    localparam logic [7:0] CPDB_IDX_EVENT = 8'hA0;
    localparam logic [7:0] CPDB_IDX_ATTACH = 8'hA1;
    // control field positions
    localparam int CPDB_CTL_ACTIVE = 7;
    localparam int CPDB_CTL_CLEAR = 4;
    localparam int CPDB_CTL_DIR = 3;
    localparam int CPDB_CTL_HALT = 1;
    localparam int CPDB_CTL_LAUNCH = 0;
    // config field positions
    localparam int CPDB_CFG_FREE = 7;
    localparam int CPDB_CFG_ACKSTYLE = 6;
    localparam int CPDB_CFG_ENABLE = 3;
    // event status field positions
    localparam int CPDB_EVT_DONE = 0;
    localparam int CPDB_EVT_WRAP = 1;
    // reset values
    localparam logic [7:0] CPDB_RST_BYTE = 8'h00;
    localparam logic [31:0] CPDB_RST_COUNT = 32'h0000_0000;
    // widths and burst sizes
    localparam int CPDB_LEVEL_W = 13;
    localparam logic [12:0] CPDB_BURST16 = 13'h0010;
    localparam logic [12:0] CPDB_BURST32 = 13'h0020;
    localparam logic [12:0] CPDB_BURST64 = 13'h0040;
    localparam logic [12:0] CPDB_ONE_LEVEL = 13'h0001;
    localparam logic [31:0] CPDB_ONE_COUNT = 32'h0000_0001;

    // ahb address phase capture
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] index;
    } cpdb_aphase_t;

    // byte stream toward/from the attached fifo
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } cpdb_byte_t;

    typedef enum logic [1:0] {
        CPDB_IDLE = 2'b01,
        CPDB_RUN = 2'b10
    } cpdb_state_t;
endpackage

// ===== design/cpdb_channel.sv
// cpu port dma channel: control/status, fifo level, byte counter, data ports
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps

// Operation
// - active flag high exactly while transferring
// - fifo attach locked while active
// - count clear zeroes counter unless active
// - direction bit picks write or read
// - halt ends transfer, sets completion
// - launch one starts, zero ignored
// - read direction: level shows data remaining
// - write direction: level shows free space
// - count mode counts down, ends at zero
// - free-run mode counts up from value
// - wrap sets wrap flag, keeps counting
// - port reads pop fifo data
// - port writes push fifo data
// - ack style: strobe or port access
// - free counting selects count mode
// - channel enable gates channel access
// - request only at burst or remainder
module cpdb_channel
    import cpdb_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic TRANSFER_ACK_N_I,
    output logic TRANSFER_REQUEST_N_O,
    input wire logic [12:0] FIFO_DATA_AVAIL_I,
    input wire logic [12:0] FIFO_SPACE_AVAIL_I,
    input wire logic [7:0] FIFO_RD_DATA_I,
    output logic FIFO_RD_POP_O,
    output logic [7:0] FIFO_WR_DATA_O,
    output logic FIFO_WR_PUSH_O,
    output logic [7:0] FIFO_ATTACH_O,
    output logic [7:0] ACK_RD_DATA_O,
    input wire logic [7:0] ACK_WR_DATA_I
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    cpdb_aphase_t aph_r;
    cpdb_state_t state_r;
    logic [7:0] cfg_r;
    logic dir_r;
    logic [7:0] attach_r;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic done_flag_r;
    logic wrap_flag_r;
    logic ack_meta_r;
    logic ack_sync_r;
    logic ack_prev_r;
    logic [7:0] rd_data_r;
    cpdb_byte_t push_r;
    logic pop_r;
    logic active;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;
    logic launch_wr;
    logic halt_wr;
    logic clear_wr;
    logic ack_edge;
    logic port_xfer;
    logic byte_move;
    logic last_byte;
    logic wrap;
    logic [12:0] level;
    logic [12:0] burst;
    logic [12:0] need;
    logic [31:0] rdata;

    assign active = (state_r == CPDB_RUN);

    // ------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ------------------------------------------------------------
    // capture address phase
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            aph_r <= '0;
        end else if (HREADY_I) begin
            aph_r.valid <= HSEL_I && HTRANS_I[1];
            aph_r.write <= HWRITE_I;
            aph_r.index <= HADDR_I[9:2];
        end
    end

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign wr_en = aph_r.valid && aph_r.write;
    assign rd_en = aph_r.valid && !aph_r.write;
    assign wbyte = HWDATA_I[7:0];
    assign HRDATA_O = rdata;

    // control strobes decoded from the data phase
    assign launch_wr = wr_en && (aph_r.index == CPDB_IDX_CONTROL) && wbyte[CPDB_CTL_LAUNCH];
    assign halt_wr = wr_en && (aph_r.index == CPDB_IDX_CONTROL) && wbyte[CPDB_CTL_HALT];
    assign clear_wr = wr_en && (aph_r.index == CPDB_IDX_CONTROL) && wbyte[CPDB_CTL_CLEAR];

    // ------------------------------------------------------------
    // configuration, direction and fifo attach
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            cfg_r <= CPDB_RST_BYTE;
            dir_r <= 1'b0;
            attach_r <= CPDB_RST_BYTE;
        end else if (wr_en) begin
            if (aph_r.index == CPDB_IDX_CONFIG) begin
                cfg_r <= wbyte & 8'hCB; // reserved bits stay zero
            end else if (aph_r.index == CPDB_IDX_CONTROL) begin
                dir_r <= wbyte[CPDB_CTL_DIR];
            end else if (aph_r.index == CPDB_IDX_ATTACH && !active) begin
                attach_r <= wbyte;
            end
        end
    end
    assign FIFO_ATTACH_O = attach_r;

    // ------------------------------------------------------------
    // acknowledge strobe synchroniser and falling edge
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            ack_meta_r <= 1'b1;
            ack_sync_r <= 1'b1;
            ack_prev_r <= 1'b1;
        end else begin
            ack_meta_r <= TRANSFER_ACK_N_I;
            ack_sync_r <= ack_meta_r;
            ack_prev_r <= ack_sync_r;
        end
    end
    assign ack_edge = ack_prev_r && !ack_sync_r;

    // ------------------------------------------------------------
    // byte movement: strobe or data-port access
    // ------------------------------------------------------------
    always_comb begin
        port_xfer = 1'b0;
        if (dir_r) begin
            port_xfer = rd_en && (aph_r.index == CPDB_IDX_RD_PORT0
                || aph_r.index == CPDB_IDX_RD_PORT1);
        end else begin
            port_xfer = wr_en && (aph_r.index == CPDB_IDX_WR_PORT0
                || aph_r.index == CPDB_IDX_WR_PORT1);
        end
    end
    assign byte_move = active && cfg_r[CPDB_CFG_ENABLE]
        && (cfg_r[CPDB_CFG_ACKSTYLE] ? port_xfer : ack_edge);
    assign last_byte = !cfg_r[CPDB_CFG_FREE] && (count_r == CPDB_ONE_COUNT);
    assign wrap = cfg_r[CPDB_CFG_FREE] && (count_r == 32'hFFFF_FFFF);

    // fifo push/pop pulses and read data capture
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            push_r <= '0;
            pop_r <= 1'b0;
            rd_data_r <= CPDB_RST_BYTE;
        end else begin
            push_r.valid <= byte_move && !dir_r;
            pop_r <= byte_move && dir_r;
            if (byte_move && !dir_r) begin
                push_r.data <= cfg_r[CPDB_CFG_ACKSTYLE] ? wbyte : ACK_WR_DATA_I;
            end
            if (byte_move && dir_r) begin
                rd_data_r <= FIFO_RD_DATA_I;
            end
        end
    end
    assign FIFO_WR_PUSH_O = push_r.valid;
    assign FIFO_WR_DATA_O = push_r.data;
    assign FIFO_RD_POP_O = pop_r;
    assign ACK_RD_DATA_O = rd_data_r;

    // ------------------------------------------------------------
    // transfer state
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_r <= CPDB_IDLE;
        end else begin
            case (state_r)
                CPDB_IDLE: begin
                    if (launch_wr) begin
                        state_r <= CPDB_RUN;
                    end
                end
                CPDB_RUN: begin
                    if (halt_wr || (byte_move && last_byte)) begin
                        state_r <= CPDB_IDLE;
                    end
                end
                default: begin
                    state_r <= CPDB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // byte counter
    // ------------------------------------------------------------
    always_comb begin
        count_nxt = count_r;
        if (byte_move) begin
            count_nxt = cfg_r[CPDB_CFG_FREE] ? count_r + CPDB_ONE_COUNT
                : count_r - CPDB_ONE_COUNT;
        end else if (clear_wr && !active) begin
            count_nxt = CPDB_RST_COUNT;
        end else if (wr_en && !active) begin
            if (aph_r.index == CPDB_IDX_COUNT_B3) begin
                count_nxt[31:24] = wbyte;
            end else if (aph_r.index == CPDB_IDX_COUNT_B2) begin
                count_nxt[23:16] = wbyte;
            end else if (aph_r.index == CPDB_IDX_COUNT_B1) begin
                count_nxt[15:8] = wbyte;
            end else if (aph_r.index == CPDB_IDX_COUNT_B0) begin
                count_nxt[7:0] = wbyte;
            end
        end
    end
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            count_r <= CPDB_RST_COUNT;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------
    // event flags: set wins over clear, write one to clear
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            done_flag_r <= 1'b0;
            wrap_flag_r <= 1'b0;
        end else begin
            if (active && (halt_wr || (byte_move && last_byte))) begin
                done_flag_r <= 1'b1;
            end else if (wr_en && aph_r.index == CPDB_IDX_EVENT && wbyte[CPDB_EVT_DONE]) begin
                done_flag_r <= 1'b0;
            end
            if (byte_move && wrap) begin
                wrap_flag_r <= 1'b1;
            end else if (wr_en && aph_r.index == CPDB_IDX_EVENT && wbyte[CPDB_EVT_WRAP]) begin
                wrap_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // fifo level and request
    // ------------------------------------------------------------
    assign level = dir_r ? FIFO_DATA_AVAIL_I : FIFO_SPACE_AVAIL_I;
    always_comb begin
        case (cfg_r[1:0])
            2'b01: burst = CPDB_BURST16;
            2'b10: burst = CPDB_BURST32;
            2'b11: burst = CPDB_BURST64;
            default: burst = CPDB_ONE_LEVEL;
        endcase
        need = burst;
        if (!cfg_r[CPDB_CFG_FREE] && count_r < {19'h0, burst}) begin
            need = count_r[12:0];
        end
    end

    // request is registered; it drops the cycle after level falls below need
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            TRANSFER_REQUEST_N_O <= 1'b1;
        end else begin
            TRANSFER_REQUEST_N_O <= !(active && cfg_r[CPDB_CFG_ENABLE]
                && !cfg_r[CPDB_CFG_ACKSTYLE] && level >= need && need != 13'h0000);
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        if (aph_r.index == CPDB_IDX_CONFIG) begin
            rdata[7:0] = cfg_r;
        end else if (aph_r.index == CPDB_IDX_CONTROL) begin
            rdata[CPDB_CTL_ACTIVE] = active;
            rdata[CPDB_CTL_DIR] = dir_r;
        end else if (aph_r.index == CPDB_IDX_LEVEL_H) begin
            rdata[4:0] = level[12:8];
        end else if (aph_r.index == CPDB_IDX_LEVEL_L) begin
            rdata[7:0] = level[7:0];
        end else if (aph_r.index == CPDB_IDX_COUNT_B3) begin
            rdata[7:0] = count_r[31:24];
        end else if (aph_r.index == CPDB_IDX_COUNT_B2) begin
            rdata[7:0] = count_r[23:16];
        end else if (aph_r.index == CPDB_IDX_COUNT_B1) begin
            rdata[7:0] = count_r[15:8];
        end else if (aph_r.index == CPDB_IDX_COUNT_B0) begin
            rdata[7:0] = count_r[7:0];
        end else if (aph_r.index == CPDB_IDX_RD_PORT0 || aph_r.index == CPDB_IDX_RD_PORT1) begin
            rdata[7:0] = FIFO_RD_DATA_I;
        end else if (aph_r.index == CPDB_IDX_EVENT) begin
            rdata[CPDB_EVT_DONE] = done_flag_r;
            rdata[CPDB_EVT_WRAP] = wrap_flag_r;
        end else if (aph_r.index == CPDB_IDX_ATTACH) begin
            rdata[7:0] = attach_r;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_launch_starts: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (!active && launch_wr) |=> active) else $error("launch did not start");
    chk_halt_ends: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (active && halt_wr) |=> (!active && done_flag_r)) else $error("halt failed");
    chk_clear_count: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (!active && clear_wr && !byte_move) |=> count_r == 32'h0) else $error("clear failed");
    chk_clear_ignored: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (active && clear_wr && !byte_move) |=> $stable(count_r)) else $error("clear not ignored");
    chk_attach_lock: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        active |=> $stable(attach_r)) else $error("attach changed while active");
    chk_count_down: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (byte_move && !cfg_r[CPDB_CFG_FREE]) |=> count_r == $past(count_r) - 32'h1)
        else $error("count down wrong");
    chk_count_up: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (byte_move && cfg_r[CPDB_CFG_FREE]) |=> count_r == $past(count_r) + 32'h1)
        else $error("count up wrong");
    chk_final_byte: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (byte_move && last_byte) |=> (!active && done_flag_r)) else $error("no completion");
    chk_wrap_flag: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (byte_move && wrap) |=> (wrap_flag_r && count_r == 32'h0)) else $error("wrap lost");
    chk_request_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (!active) |=> ##1 (TRANSFER_REQUEST_N_O || active)) else $error("request while idle");
    // guards on wrap, strobe, port and request paths
    chk_wrap_continues: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (byte_move && wrap) |=> active) else $error("wrap stopped transfer");
    chk_request_below: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (level < need) |=> TRANSFER_REQUEST_N_O) else $error("request below threshold");
    chk_strobe_push: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (active && cfg_r[CPDB_CFG_ENABLE] && !cfg_r[CPDB_CFG_ACKSTYLE] && ack_edge && !dir_r)
        |=> FIFO_WR_PUSH_O) else $error("strobe byte not pushed");
    chk_port_pop: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (active && cfg_r[CPDB_CFG_ENABLE] && cfg_r[CPDB_CFG_ACKSTYLE] && dir_r && rd_en
        && aph_r.index == CPDB_IDX_RD_PORT0) |=> FIFO_RD_POP_O) else $error("port read no pop");

    // cover points for the main scenarios
    cov_halt: cover property (@(posedge REF_CLK_I) active && halt_wr);
    cov_strobe_byte: cover property (@(posedge REF_CLK_I) ack_edge && byte_move);
    cov_port_read: cover property (@(posedge REF_CLK_I) byte_move && dir_r);
    cov_final: cover property (@(posedge REF_CLK_I) byte_move && last_byte);
    cov_wrap: cover property (@(posedge REF_CLK_I) byte_move && wrap);
endmodule // cpdb_channel

// ===== bench/cpdb_ext_dma.sv
// model of the external dma controller that answers the request line
`timescale 1ns/1ps
module cpdb_ext_dma (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [3:0] gap_i,
    input wire logic req_n_i,
    output logic ack_n_o,
    output logic [7:0] wr_data_o
);
    logic [3:0] wait_r;

    // -----------------------------------------------------------------
    // strobe: low for two cycles, then high for at least gap plus one cycles, data held
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            ack_n_o <= 1'b1;
            wait_r <= 4'h0;
            wr_data_o <= 8'hA5;
        end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
            if (wait_r == gap_i + 4'h1) begin
                ack_n_o <= 1'b1;
            end
        end else if (req_n_i == 1'b0) begin
            ack_n_o <= 1'b0;
            wr_data_o <= wr_data_o + 8'h11; // new byte with each strobe
            wait_r <= gap_i + 4'h2;
        end
    end
endmodule // cpdb_ext_dma

// ===== bench/cpdb_channel_tb.sv
// self-checking bench of the cpu port dma channel
`timescale 1ns/1ps
module cpdb_channel_tb;
    import cpdb_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [12:0] data_avail = 13'h0000;
    logic [12:0] space_avail = 13'h0000;
    logic [7:0] rd_head = 8'h00;
    logic dma_run = 1'b0;
    logic [31:0] hrdata, rd, cnt_v;
    logic hreadyout, hresp, ack_n, req_n, pop, push;
    logic [7:0] wr_byte, attach, ack_rd, ack_wr, b;
    logic [7:0] push_q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 32'h75e0;
    int n_pop = 0;
    int p0, i;

    always #5 ref_clk = ~ref_clk;

    cpdb_channel cpdb_channel_inst (
        .REF_CLK_I(ref_clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
        .TRANSFER_ACK_N_I(ack_n), .TRANSFER_REQUEST_N_O(req_n),
        .FIFO_DATA_AVAIL_I(data_avail), .FIFO_SPACE_AVAIL_I(space_avail),
        .FIFO_RD_DATA_I(rd_head), .FIFO_RD_POP_O(pop), .FIFO_WR_DATA_O(wr_byte),
        .FIFO_WR_PUSH_O(push), .FIFO_ATTACH_O(attach), .ACK_RD_DATA_O(ack_rd),
        .ACK_WR_DATA_I(ack_wr));

    cpdb_ext_dma cpdb_ext_dma_inst (.clk_i(ref_clk), .rst_i(rst), .run_i(dma_run),
        .gap_i(4'h6), .req_n_i(req_n), .ack_n_o(ack_n), .wr_data_o(ack_wr));

    // -----------------------------------------------------------------
    // fifo side monitor and expectation helpers
    // -----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (push === 1'b1) push_q.push_back(wr_byte);
        if (pop === 1'b1) n_pop++;
    end
    function automatic logic [7:0] ctl_exp(input logic act, input logic dir);
        return {act, 3'b000, dir, 3'b000};
    endfunction
    function automatic logic [12:0] level_exp(input logic dir, input logic [12:0] d,
                                              input logic [12:0] s);
        return dir ? d : s;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one ahb-lite single word transfer
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rdv = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] dummy;
        ahb(1'b1, idx, {24'h0, d}, dummy);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] v;
        ahb(1'b0, idx, 32'h0, v);
        chk(v, {24'h0, exp}, what);
    endtask
    task automatic set_count(input logic [31:0] c);
        wr(CPDB_IDX_COUNT_B3, c[31:24]);
        wr(CPDB_IDX_COUNT_B2, c[23:16]);
        wr(CPDB_IDX_COUNT_B1, c[15:8]);
        wr(CPDB_IDX_COUNT_B0, c[7:0]);
    endtask
    // read the count most significant byte first
    task automatic rd_count(output logic [31:0] c);
        logic [31:0] v;
        ahb(1'b0, CPDB_IDX_COUNT_B3, 32'h0, v);
        c[31:24] = v[7:0];
        ahb(1'b0, CPDB_IDX_COUNT_B2, 32'h0, v);
        c[23:16] = v[7:0];
        ahb(1'b0, CPDB_IDX_COUNT_B1, 32'h0, v);
        c[15:8] = v[7:0];
        ahb(1'b0, CPDB_IDX_COUNT_B0, 32'h0, v);
        c[7:0] = v[7:0];
    endtask
    task automatic launch(input logic [7:0] cfg, input logic [31:0] c, input logic dir);
        wr(CPDB_IDX_CONFIG, cfg);
        wr(CPDB_IDX_EVENT, 8'h03);
        set_count(c);
        wr(CPDB_IDX_CONTROL, {4'h0, dir, 3'b001});
        push_q.delete();
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    // -----------------------------------------------------------------
    // test sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        space_avail <= 13'($random(seed)) | 13'h0100;
        data_avail <= 13'($random(seed)) | 13'h0100;
        @(posedge ref_clk);
        rdc(CPDB_IDX_CONTROL, 8'h00, "control at reset");
        rdc(CPDB_IDX_COUNT_B0, 8'h00, "count at reset");
        rdc(8'h90, 8'h00, "unmapped read");
        chk({31'h0, hresp}, 32'h0, "okay response");
        $display("test reset values done");
        cnt_v = $random(seed);
        set_count(cnt_v);
        rd_count(rd);
        chk(rd, cnt_v, "count readback");
        wr(CPDB_IDX_CONTROL, 8'h10);
        rd_count(rd);
        chk(rd, 32'h0, "count clear");
        $display("test count load and clear done");
        launch(8'h48, 32'h3, 1'b0);
        rdc(CPDB_IDX_CONTROL, ctl_exp(1'b1, 1'b0), "active after launch");
        wr(CPDB_IDX_ATTACH, 8'h5A);
        wr(CPDB_IDX_CONTROL, 8'h10);
        wr(CPDB_IDX_CONTROL, 8'h00);
        chk(attach, 8'h00, "attach locked");
        rd_count(rd);
        chk(rd, 32'h3, "clear and zero launch ignored");
        rdc(CPDB_IDX_CONTROL, ctl_exp(1'b1, 1'b0), "zero launch no effect");
        rdc(CPDB_IDX_LEVEL_L, 8'(level_exp(1'b0, data_avail, space_avail)), "free space");
        for (i = 0; i < 3; i++) begin
            b = $random(seed);
            wr(i[0] ? CPDB_IDX_WR_PORT1 : CPDB_IDX_WR_PORT0, b);
            repeat (2) @(posedge ref_clk);
            chk(push_q[i], b, "pushed byte");
        end
        chk(push_q.size(), 3, "push count");
        rdc(CPDB_IDX_CONTROL, ctl_exp(1'b0, 1'b0), "done after count");
        rdc(CPDB_IDX_EVENT, 8'h01, "completion flag");
        wr(CPDB_IDX_ATTACH, 8'h5A);
        repeat (2) @(posedge ref_clk);
        chk(attach, 8'h5A, "attach free when idle");
        $display("test port write count mode done");
        rd_head <= $random(seed);
        launch(8'h48, 32'h10, 1'b1);
        rdc(CPDB_IDX_LEVEL_H, 8'(level_exp(1'b1, data_avail, space_avail) >> 8), "data");
        p0 = n_pop;
        rdc(CPDB_IDX_RD_PORT0, rd_head, "read port");
        repeat (2) @(posedge ref_clk);
        chk(n_pop, p0 + 1, "one pop");
        chk(ack_rd, rd_head, "popped byte");
        rd_count(rd);
        chk(rd, 32'hF, "count after read");
        wr(CPDB_IDX_CONTROL, 8'h0A);
        rdc(CPDB_IDX_CONTROL, ctl_exp(1'b0, 1'b1), "halted");
        rdc(CPDB_IDX_EVENT, 8'h01, "completion on halt");
        $display("test read port and halt done");
        launch(8'h40, 32'h2, 1'b0);
        wr(CPDB_IDX_WR_PORT0, 8'h3C);
        repeat (2) @(posedge ref_clk);
        chk(push_q.size(), 0, "disabled channel");
        wr(CPDB_IDX_CONTROL, 8'h02);
        $display("test channel disabled done");
        launch(8'hC8, 32'hFFFF_FFFF, 1'b0);
        wr(CPDB_IDX_WR_PORT0, 8'h11);
        rd_count(rd);
        chk(rd, 32'h0, "wrapped count");
        wr(CPDB_IDX_WR_PORT1, 8'h22);
        rd_count(rd);
        chk(rd, 32'h1, "count up");
        rdc(CPDB_IDX_EVENT, 8'h02, "wrap flag");
        rdc(CPDB_IDX_CONTROL, ctl_exp(1'b1, 1'b0), "free run goes on");
        wr(CPDB_IDX_CONTROL, 8'h02);
        $display("test free run done");
        launch(8'h08, 32'h4, 1'b0);
        dma_run <= 1'b1;
        rd = 32'h80;
        for (i = 0; i < 200 && rd[7] !== 1'b0; i++) ahb(1'b0, CPDB_IDX_CONTROL, 32'h0, rd);
        chk(rd, 32'h0, "strobe transfer ends");
        chk(push_q.size(), 4, "strobe byte count");
        for (i = 0; i < 4; i++) chk(push_q[i], 8'hA5 + 8'h11 * (i + 1), "strobe byte");
        dma_run <= 1'b0;
        $display("test strobe transfer done");
        space_avail <= 13'd20;
        launch(8'h0B, 32'd100, 1'b0);
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            chk(req_n, 1'b1, "no request below burst");
        end
        space_avail <= 13'd100;
        repeat (4) @(posedge ref_clk);
        chk(req_n, 1'b0, "request at burst");
        wr(CPDB_IDX_CONTROL, 8'h02);
        space_avail <= 13'd20;
        launch(8'h0B, 32'd5, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk(req_n, 1'b0, "request at remainder");
        wr(CPDB_IDX_CONTROL, 8'h02);
        launch(8'h09, 32'd100, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk(req_n, 1'b0, "request at burst 16");
        wr(CPDB_IDX_CONTROL, 8'h02);
        launch(8'h0A, 32'd100, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk(req_n, 1'b1, "no request below burst 32");
        wr(CPDB_IDX_CONTROL, 8'h02);
        repeat (4) @(posedge ref_clk);
        chk(req_n, 1'b1, "request dropped when idle");
        $display("test request threshold done");
        end_sim();
    end
endmodule // cpdb_channel_tb
